// ==== design/wp_cfg_defs.svh ====
// offsets, field positions, reset values and timing counts
`ifndef WP_CFG_DEFS_SVH
`define WP_CFG_DEFS_SVH
// ----------------------------------------
// command codes
// ----------------------------------------
`define WPC_CMD 8'hd0
`define CFG_CMD 8'hd1
// ----------------------------------------
// reset values
// ----------------------------------------
`define WPC_RESET 8'h00
`define CFG_RESET 8'h07
// ----------------------------------------
// field positions
// ----------------------------------------
`define WPC_LOCK_BIT 0
`define WPC_RST_BIT 1
`define CFG_MON_BIT 0
`define CFG_ALERT_BIT 1
`define CFG_FAULT_BIT 2
`define CFG_TMO_BIT 3
`define CFG_PHASE_HI 7
`define CFG_PHASE_LO 6
`define PHASE_SEL_TWO 2'h1
`define PHASE_ONE 2'h1
`define PHASE_TWO 2'h2
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ 20000000
`define TMO_MS 35
`define TMO_CYCLES ((`TMO_MS * `CLK_HZ) / 1000)
`define BUS_ADDR 7'h40
`endif

// ==== design/wp_cfg_pkg.sv ====
// types for the write-protect and configuration register bank
package wp_cfg_pkg;
   // ----------------------------------------
   // serial slave states
   // ----------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_CMD,
      ST_CMD_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RDATA_ACK,
      ST_IGNORE
   } bus_state_t;
endpackage

// ==== design/write_protect_and_config_regs.sv ====
// write-protect and maker config registers behind a pmbus slave
//
// Behaviour
// - writing 1 to the reset bit restores power-on values unless locked.
// - setting the protect bit freezes the lockable registers read-only.
// - protection, with lockable writes refused, holds until power-on reset.
// - config bits 7:6 pick light-load phases: 01 gives two, else one.
// - config bit 3 set: release the bus after 35 ms idle; bit is lockable.
// - config bit 2 gates the fault pin drive and resets to 1.
// - config bit 1 gates the active-low alert pin.
// - config bit 0 starts the monitor adc converting.
`timescale 1ns/100ps
`include "wp_cfg_defs.svh"
module write_protect_and_config_regs #(
   parameter logic [6:0] BUS_ADDR = `BUS_ADDR,
   parameter int unsigned TIMEOUT_CYCLES = `TMO_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   input wire logic i_fault_req,
   input wire logic i_alert_req,
   output logic o_fault,
   output logic o_fault_oe,
   output logic o_alert_n,
   output logic o_alert_n_oe,
   output logic [1:0] o_light_load_phase_count,
   output logic o_bus_inactivity_release_enable,
   output logic o_monitor_enable,
   output logic o_locked
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [2:0] scl_s_q;
   logic [2:0] sda_s_q;
   logic scl_f_q, sda_f_q, scl_p_q, sda_p_q;
   logic scl_rise, scl_fall, bus_start, bus_stop, activity;
   wp_cfg_pkg::bus_state_t state_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q, cmd_q, tx_q, wr_data_q, rd_data;
   logic rw_q, drive_low_q, wr_stb_q, tmo_hit;
   logic [31:0] tmo_q;
   logic [7:0] wpc_q, cfg_q;
   logic lock;

   assign lock = wpc_q[`WPC_LOCK_BIT];

   // ----------------------------------------
   // pin synchronisers and event detect
   // ----------------------------------------
   // three stages; filtered level moves once stages two and three agree
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         scl_f_q <= 1'b1;
         sda_f_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[1:0], i_scl};
         sda_s_q <= {sda_s_q[1:0], i_sda};
         if (scl_s_q[1] == scl_s_q[2]) begin
            scl_f_q <= scl_s_q[2];
         end
         if (sda_s_q[1] == sda_s_q[2]) begin
            sda_f_q <= sda_s_q[2];
         end
         scl_p_q <= scl_f_q;
         sda_p_q <= sda_f_q;
      end
   end

   assign scl_rise = scl_f_q & ~scl_p_q;
   assign scl_fall = ~scl_f_q & scl_p_q;
   assign bus_start = scl_f_q & scl_p_q & ~sda_f_q & sda_p_q;
   assign bus_stop = scl_f_q & scl_p_q & sda_f_q & ~sda_p_q;
   assign activity = (scl_f_q ^ scl_p_q) | (sda_f_q ^ sda_p_q);

   // ----------------------------------------
   // bus inactivity timer
   // ----------------------------------------
   // only counts while a transaction is open and not being ignored, address byte included
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tmo_q <= 32'h0;
      end else if (activity || state_q == wp_cfg_pkg::ST_IDLE ||
                   state_q == wp_cfg_pkg::ST_IGNORE || tmo_hit) begin
         tmo_q <= 32'h0;
      end else begin
         tmo_q <= tmo_q + 32'h1;
      end
   end

   assign tmo_hit = cfg_q[`CFG_TMO_BIT] &&
                    (tmo_q >= 32'(TIMEOUT_CYCLES) - 32'h1);

   // ----------------------------------------
   // read data select
   // ----------------------------------------
   always_comb begin
      case (cmd_q)
         `WPC_CMD: rd_data = wpc_q;
         `CFG_CMD: rd_data = cfg_q;
         default: rd_data = 8'h00;
      endcase
   end

   // ----------------------------------------
   // serial slave state machine
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= wp_cfg_pkg::ST_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         cmd_q <= 8'h00;
         tx_q <= 8'h00;
         wr_data_q <= 8'h00;
         rw_q <= 1'b0;
         drive_low_q <= 1'b0;
         wr_stb_q <= 1'b0;
      end else begin
         wr_stb_q <= 1'b0;
         if (tmo_hit) begin
            state_q <= wp_cfg_pkg::ST_IDLE;
            drive_low_q <= 1'b0;
         end else if (bus_stop) begin
            state_q <= wp_cfg_pkg::ST_IDLE;
            drive_low_q <= 1'b0;
         end else if (bus_start) begin
            state_q <= wp_cfg_pkg::ST_ADDR;
            cnt_q <= 4'h0;
            drive_low_q <= 1'b0;
         end else if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_f_q};
            cnt_q <= cnt_q + 4'h1;
         end else if (scl_fall) begin
            case (state_q)
               wp_cfg_pkg::ST_ADDR: begin
                  if (cnt_q == 4'h8) begin
                     if (sh_q[7:1] == BUS_ADDR) begin
                        state_q <= wp_cfg_pkg::ST_ADDR_ACK;
                        rw_q <= sh_q[0];
                        drive_low_q <= 1'b1;
                     end else begin
                        state_q <= wp_cfg_pkg::ST_IGNORE;
                     end
                  end
               end
               wp_cfg_pkg::ST_ADDR_ACK: begin
                  cnt_q <= 4'h0;
                  if (rw_q) begin
                     state_q <= wp_cfg_pkg::ST_RDATA;
                     tx_q <= {rd_data[6:0], 1'b0};
                     drive_low_q <= ~rd_data[7];
                  end else begin
                     state_q <= wp_cfg_pkg::ST_CMD;
                     drive_low_q <= 1'b0;
                  end
               end
               wp_cfg_pkg::ST_CMD: begin
                  if (cnt_q == 4'h8) begin
                     cmd_q <= sh_q;
                     state_q <= wp_cfg_pkg::ST_CMD_ACK;
                     drive_low_q <= 1'b1;
                  end
               end
               wp_cfg_pkg::ST_CMD_ACK: begin
                  cnt_q <= 4'h0;
                  state_q <= wp_cfg_pkg::ST_WDATA;
                  drive_low_q <= 1'b0;
               end
               wp_cfg_pkg::ST_WDATA: begin
                  if (cnt_q == 4'h8) begin
                     wr_data_q <= sh_q;
                     wr_stb_q <= 1'b1;
                     state_q <= wp_cfg_pkg::ST_WDATA_ACK;
                     drive_low_q <= 1'b1;
                  end
               end
               wp_cfg_pkg::ST_RDATA: begin
                  if (cnt_q == 4'h8) begin
                     state_q <= wp_cfg_pkg::ST_RDATA_ACK;
                     drive_low_q <= 1'b0;
                  end else begin
                     drive_low_q <= ~tx_q[7];
                     tx_q <= {tx_q[6:0], 1'b0};
                  end
               end
               wp_cfg_pkg::ST_WDATA_ACK,
               wp_cfg_pkg::ST_RDATA_ACK: begin
                  state_q <= wp_cfg_pkg::ST_IGNORE;
                  drive_low_q <= 1'b0;
               end
               default: begin
                  drive_low_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // register bank
   // ----------------------------------------
   // only power-on reset clears the lock
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wpc_q <= `WPC_RESET;
         cfg_q <= `CFG_RESET;
      end else if (wr_stb_q && cmd_q == `WPC_CMD && !lock) begin
         if (wr_data_q[`WPC_RST_BIT]) begin
            wpc_q <= `WPC_RESET;
            cfg_q <= `CFG_RESET;
         end else begin
            wpc_q <= {7'h00, wr_data_q[`WPC_LOCK_BIT]};
         end
      end else if (wr_stb_q && cmd_q == `CFG_CMD) begin
         cfg_q <= {wr_data_q[7:6], 2'h0,
                   lock ? cfg_q[`CFG_TMO_BIT] : wr_data_q[3],
                   wr_data_q[2:0]};
      end
   end

   // ----------------------------------------
   // pin gating and decoded outputs
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_fault <= 1'b0;
         o_fault_oe <= 1'b0;
         o_alert_n_oe <= 1'b0;
         o_light_load_phase_count <= `PHASE_ONE;
      end else begin
         o_fault <= i_fault_req;
         o_fault_oe <= cfg_q[`CFG_FAULT_BIT];
         o_alert_n_oe <= cfg_q[`CFG_ALERT_BIT] & i_alert_req;
         o_light_load_phase_count <=
            (cfg_q[7:6] == `PHASE_SEL_TWO) ? `PHASE_TWO : `PHASE_ONE;
      end
   end

   assign o_alert_n = 1'b0;
   assign o_sda = 1'b0;
   assign o_sda_oe = drive_low_q;
   assign o_monitor_enable = cfg_q[`CFG_MON_BIT];
   assign o_bus_inactivity_release_enable = cfg_q[`CFG_TMO_BIT];
   assign o_locked = lock;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   a_reset_all_write: assert property (
      wr_stb_q && cmd_q == `WPC_CMD && wr_data_q[1] && !lock
      |=> wpc_q == `WPC_RESET && cfg_q == `CFG_RESET)
      else $error("reset-all write did not restore defaults");
   a_reset_when_locked: assert property (
      wr_stb_q && cmd_q == `WPC_CMD && lock |=> $stable(wpc_q))
      else $error("locked control register changed");
   a_lock_sets: assert property (
      wr_stb_q && cmd_q == `WPC_CMD && wr_data_q[1:0] == 2'h1
      |=> lock)
      else $error("protect bit not set by write");
   a_lock_sticky: assert property (
      lock |=> lock)
      else $error("protect bit cleared without power-on");
   a_tmo_frozen: assert property (
      lock && wr_stb_q && cmd_q == `CFG_CMD |=> $stable(cfg_q[3]))
      else $error("lockable timeout bit written while locked");
   a_phase_decode: assert property (
      ##1 o_light_load_phase_count ==
      (($past(cfg_q[7:6]) == 2'h1) ? 2'h2 : 2'h1))
      else $error("light-load phase count wrong");
   a_bus_release: assert property (
      tmo_hit |=> state_q == wp_cfg_pkg::ST_IDLE && !o_sda_oe)
      else $error("bus not released on inactivity");
   a_fault_gate: assert property (
      o_fault_oe |-> $past(cfg_q[2]))
      else $error("fault pin driven while disabled");
   a_alert_gate: assert property (
      o_alert_n_oe |-> $past(cfg_q[1]) && $past(i_alert_req))
      else $error("alert asserted while disabled");
   a_monitor_start: assert property (
      wr_stb_q && cmd_q == `CFG_CMD && wr_data_q[0] |=> o_monitor_enable)
      else $error("monitor not started");
   a_reset_bit_zero: assert property (
      !wpc_q[1])
      else $error("reset bit reads back as one");

   c_reset_all: cover property (
      wr_stb_q && cmd_q == `WPC_CMD && wr_data_q[1] && !lock);
   c_lock: cover property ($rose(lock));
   c_timeout: cover property (tmo_hit);
   c_read: cover property (state_q == wp_cfg_pkg::ST_RDATA_ACK);
endmodule

// ==== verification/bus_host.sv ====
// bus host model driving clock and data toward the slave
`timescale 1ns/100ps
module bus_host #(
   parameter logic [6:0] ADDR = 7'h40
) (
   input wire logic i_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   // idle bus: both lines released
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // one phase of 8 clocks, above the 6 clock minimum
   task automatic ph(input logic c, input logic d);
      @(posedge i_clk);
      o_scl <= c;
      o_sda_low <= d;
      repeat (7) @(posedge i_clk);
   endtask
   // data moves only while clock is low, sampled at end of high
   task automatic bit_io(input logic b, output logic s);
      ph(1'b0, o_sda_low);
      ph(1'b0, ~b);
      ph(1'b1, ~b);
      s = i_sda;
   endtask
   task automatic start();
      ph(1'b0, o_sda_low);
      ph(1'b0, 1'b0);
      ph(1'b1, 1'b0);
      ph(1'b1, 1'b1);
   endtask
   task automatic stop();
      ph(1'b0, o_sda_low);
      ph(1'b0, 1'b1);
      ph(1'b1, 1'b1);
      ph(1'b1, 1'b0);
   endtask
   // eight bits then a released ninth bit; host never acks
   task automatic byte_io(input logic [7:0] w, output logic [7:0] r,
      output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   task automatic wr(input logic [7:0] c, input logic [7:0] d,
      output logic ok);
      logic [7:0] r;
      logic a0, a1, a2;
      start();
      byte_io({ADDR, 1'b0}, r, a0);
      byte_io(c, r, a1);
      byte_io(d, r, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask
   task automatic rd(input logic [7:0] c, output logic [7:0] d,
      output logic ok);
      logic [7:0] r;
      logic a0, a1, a2, a3;
      start();
      byte_io({ADDR, 1'b0}, r, a0);
      byte_io(c, r, a1);
      start();
      byte_io({ADDR, 1'b1}, r, a2);
      byte_io(8'hff, d, a3);
      stop();
      // slave must let go of data once its byte is sent
      ok = a0 & a1 & a2 & ~a3;
   endtask
   // stop in the address ack with clock low and the slave pulling
   task automatic stall();
      logic [7:0] w;
      logic [7:0] r;
      w = {ADDR, 1'b0};
      start();
      for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
      ph(1'b0, o_sda_low);
      ph(1'b0, 1'b0);
   endtask
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the write-protect and config registers
`timescale 1ns/100ps
`include "wp_cfg_defs.svh"
module tb_top;
   localparam int TMO = 200;
   logic i_ref_clk, i_reset_n, fault_req, alert_req, ok;
   logic [7:0] d;
   wire sda, scl, low, oe, sda_o, fault, f_oe, al_n, a_oe, rel, mon, lk;
   wire [1:0] phases;
   int bad_count, compares, cycles;
   // open-drain data wire with pull-up
   assign sda = ~((oe & ~sda_o) | low);
   write_protect_and_config_regs #(
      .TIMEOUT_CYCLES(TMO)
   ) write_protect_and_config_regs_i (
      .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_scl(scl),
      .i_sda(sda), .o_sda(sda_o), .o_sda_oe(oe),
      .i_fault_req(fault_req), .i_alert_req(alert_req),
      .o_fault(fault), .o_fault_oe(f_oe), .o_alert_n(al_n),
      .o_alert_n_oe(a_oe), .o_light_load_phase_count(phases),
      .o_bus_inactivity_release_enable(rel), .o_monitor_enable(mon),
      .o_locked(lk)
   );
   bus_host bus_host_i (
      .i_clk(i_ref_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(low)
   );
   // clock and hang guard
   initial begin
      i_ref_clk = 1'b0;
      forever #25 i_ref_clk = ~i_ref_clk;
   end
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         wrap_up();
      end
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic w(input logic [7:0] c, input logic [7:0] v);
      bus_host_i.wr(c, v, ok);
      chk({7'h00, ok}, 8'h01);
   endtask
   task automatic r(input logic [7:0] c, input logic [7:0] exp);
      bus_host_i.rd(c, d, ok);
      chk({7'h00, ok}, 8'h01);
      chk(d, exp);
   endtask
   task automatic ports(input logic [7:0] exp);
      chk({2'h0, phases, rel, mon, f_oe, lk}, exp);
   endtask
   task automatic por();
      @(posedge i_ref_clk);
      i_reset_n <= 1'b0;
      repeat (10) @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      repeat (6) @(posedge i_ref_clk);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      ports(8'h16);
      r(`WPC_CMD, `WPC_RESET);
      r(`CFG_CMD, `CFG_RESET);
      r(8'hd5, 8'h00);
   endtask
   task automatic t_phase();
      for (int v = 0; v < 4; v++) begin
         w(`CFG_CMD, {v[1:0], 6'h3f});
         r(`CFG_CMD, {v[1:0], 6'h0f});
         chk({6'h00, phases}, (v == 1) ? 8'h02 : 8'h01);
      end
   endtask
   task automatic t_pins();
      w(`CFG_CMD, 8'h00);
      @(posedge i_ref_clk);
      fault_req <= 1'b1;
      alert_req <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      chk({4'h0, f_oe, a_oe, rel, mon}, 8'h00);
      w(`CFG_CMD, 8'h0f);
      chk({2'h0, al_n, fault, f_oe, a_oe, rel, mon}, 8'h1f);
      alert_req <= 1'b0;
      fault_req <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      chk({6'h00, fault, a_oe}, 8'h00);
   endtask
   task automatic t_timeout();
      w(`CFG_CMD, 8'h00);
      bus_host_i.stall();
      repeat (TMO + 20) @(posedge i_ref_clk);
      chk({7'h00, oe}, 8'h01);
      bus_host_i.stop();
      w(`CFG_CMD, 8'h08);
      bus_host_i.stall();
      chk({7'h00, oe}, 8'h01);
      repeat (TMO + 20) @(posedge i_ref_clk);
      chk({7'h00, oe}, 8'h00);
      bus_host_i.stop();
   endtask
   task automatic t_soft();
      w(`CFG_CMD, 8'h48);
      ports(8'h28);
      w(`WPC_CMD, 8'h03);
      r(`CFG_CMD, 8'h07);
      r(`WPC_CMD, 8'h00);
      ports(8'h16);
   endtask
   task automatic t_lock();
      w(`CFG_CMD, 8'h08);
      w(`WPC_CMD, 8'h01);
      r(`WPC_CMD, 8'h01);
      w(`CFG_CMD, 8'h40);
      r(`CFG_CMD, 8'h48);
      w(`WPC_CMD, 8'h02);
      r(`CFG_CMD, 8'h48);
      w(`WPC_CMD, 8'h00);
      chk({7'h00, lk}, 8'h01);
      por();
      chk({7'h00, lk}, 8'h00);
      r(`CFG_CMD, 8'h07);
   endtask
   task automatic wrap_up();
      if (bad_count == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      i_reset_n = 1'b0;
      fault_req = 1'b0;
      alert_req = 1'b0;
      bad_count = 0;
      compares = 0;
      cycles = 0;
      por();
      t_reset();
      t_phase();
      t_pins();
      t_timeout();
      t_soft();
      t_lock();
      wrap_up();
   end
endmodule
